// ==== verilog/tcc_map.vh ====
// tcc_map.vh: register map, field positions, reset values and timing
// counts of the touch calibration control register bank.
// assumes 32-bit avalon-mm byte addressing, one word per register.
`ifndef TCC_MAP_VH
`define TCC_MAP_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define TCC_IDX_PWR         6'h00
`define TCC_IDX_CAL_EN      6'h01
`define TCC_IDX_CTRL_A      6'h02
`define TCC_IDX_CTRL_B      6'h03

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TCC_RST_PWR         16'h0000
`define TCC_RST_CAL_EN      16'h0000
`define TCC_RST_CTRL_A      16'h0FF0
`define TCC_RST_CTRL_B      16'h0164

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TCC_MODE_LSB        0
`define TCC_LPDLY_LSB       2
`define TCC_SWRST_BIT       10
`define TCC_STAGES          12
`define TCC_FPSKIP_LSB      12
`define TCC_LPSKIP_LSB      14
`define TCC_FFSKIP_LSB      0
`define TCC_FPHOLD_LSB      4
`define TCC_LPHOLD_LSB      8
`define TCC_TMO_LSB         12
`define TCC_FORCE_BIT       14
`define TCC_RESTART_BIT     15

// ----------------------------------------------------------------
// mode codes
// ----------------------------------------------------------------
`define TCC_MODE_FULL       2'h0
`define TCC_MODE_LOW        2'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TCC_CLK_KHZ         20000
`define TCC_FP_PERIOD_MS    36
`define TCC_LP_STEP_MS      200
`define TCC_FP_PERIOD_CYC   (`TCC_FP_PERIOD_MS * `TCC_CLK_KHZ)
`define TCC_LP_STEP_CYC     (`TCC_LP_STEP_MS * `TCC_CLK_KHZ)
`define TCC_FP_HOLD_MUL     16
`define TCC_LP_HOLD_MUL     4

`endif

// ==== verilog/tcc_hold_timer.v ====
// tcc_hold_timer.v: loadable down counter ticking once per sequence.
// assumes load, tick and clear come from logic on the same clock.
`timescale 1ns/1ps
module tcc_hold_timer #(
  parameter W = 9                      // counter width
) (
  input  wire         ref_clk_i,       // system clock
  input  wire         arst_n_i,        // async reset, low
  input  wire         clr_i,           // sync clear
  input  wire         load_i,          // (re)start the period
  input  wire [W-1:0] load_val_i,      // period in ticks
  input  wire         tick_i,          // one per sequence
  output wire         busy_o,          // period running
  output reg          done_o           // pulse at expiry
);

  reg [W-1:0] cnt_q;                   // ticks left

  // ----------------------------------------------------------------
  // counter: clear beats load, load beats tick
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q  <= {W{1'b0}};
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (clr_i) begin
        cnt_q <= {W{1'b0}};
      end else if (load_i) begin
        cnt_q <= load_val_i;           // retrigger restarts the period
      end else if (tick_i && cnt_q != {W{1'b0}}) begin
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        // last tick ends the period
        done_o <= (cnt_q == {{(W-1){1'b0}}, 1'b1});
      end
    end
  end

  assign busy_o = (cnt_q != {W{1'b0}});

endmodule

// ==== verilog/tcc_regs.v ====
// tcc_regs.v: calibration control register bank with its schedulers.
// assumes an avalon-mm master on ref_clk_i and a converter whose
// sample, sequence and proximity strobes are on the same clock.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`include "tcc_map.vh"
module tcc_regs #(
  parameter FP_PERIOD_CYC = `TCC_FP_PERIOD_CYC,  // full power interval
  parameter LP_STEP_CYC   = `TCC_LP_STEP_CYC     // low power delay step
) (
  input  wire        ref_clk_i,          // 20 MHz system clock
  input  wire        arst_n_i,           // async reset, low
  input  wire [7:0]  avs_address_i,      // byte address
  input  wire        avs_read_i,         // read request
  input  wire        avs_write_i,        // write request
  input  wire [31:0] avs_writedata_i,    // write data
  input  wire [3:0]  avs_byteenable_i,   // byte lanes
  output reg  [31:0] avs_readdata_o,     // read data
  output reg         avs_waitrequest_o,  // stall
  input  wire        sample_done_i,      // one adc sample ready
  input  wire        seq_done_i,         // one sequence finished
  input  wire        proximity_i,        // object near, level
  output reg         conv_start_o,       // start a sequence
  output reg         seq_restart_o,      // back to stage zero
  output reg  [1:0]  power_mode_o,       // operating mode
  output reg  [11:0] stage_cal_enable_o, // per stage enables
  output reg         forced_cal_o,       // recalibrate all
  output reg  [11:0] baseline_update_o,  // baseline update pulse
  output reg         sample_use_o,       // sample into average
  output reg         ff_admit_o,         // sequence into fast fifo
  output reg         cal_hold_o,         // calibration held off
  output reg         lp_entry_o          // low power timeout hit
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  reg  [15:0] pwr_q;                     // power control
  reg  [15:0] cal_en_q;                  // stage enables, skips
  reg  [15:0] ctrl_a_q;                  // hold counts, control
  reg  [15:0] ctrl_b_q;                  // recal levels
  reg         srst_q;                    // soft reset, one cycle

  wire [5:0]  idx_w = avs_address_i[7:2];  // word index
  wire        req_w = avs_read_i | avs_write_i;
  // access completes on the edge where waitrequest is low
  wire        wr_w  = avs_write_i & ~avs_waitrequest_o;
  wire [15:0] wdat_w = avs_writedata_i[15:0];

  // ----------------------------------------------------------------
  // field views
  // ----------------------------------------------------------------
  wire [1:0]  mode_w   = pwr_q[`TCC_MODE_LSB +: 2];
  wire [1:0]  lpdly_w  = pwr_q[`TCC_LPDLY_LSB +: 2];
  wire [1:0]  fpskip_w = cal_en_q[`TCC_FPSKIP_LSB +: 2];
  wire [1:0]  lpskip_w = cal_en_q[`TCC_LPSKIP_LSB +: 2];
  wire [3:0]  ffskip_w = ctrl_a_q[`TCC_FFSKIP_LSB +: 4];
  wire [3:0]  fphold_w = ctrl_a_q[`TCC_FPHOLD_LSB +: 4];
  wire [3:0]  lphold_w = ctrl_a_q[`TCC_LPHOLD_LSB +: 4];
  wire [1:0]  tmo_w    = ctrl_a_q[`TCC_TMO_LSB +: 2];
  wire        full_w   = (mode_w == `TCC_MODE_FULL);
  wire        low_w    = (mode_w == `TCC_MODE_LOW);
  // codes 01 and 11 both mean shutdown
  wire        run_w    = full_w | low_w;

  // byte-lane merge of a write into a 16-bit register
  function [15:0] merge;
    input [15:0] old;
    input [15:0] nw;
    input [1:0]  be;
    begin
      merge = {be[1] ? nw[15:8] : old[15:8],
               be[0] ? nw[7:0]  : old[7:0]};
    end
  endfunction

  wire hi_lane_w = avs_byteenable_i[1];
  wire swrst_w   = wr_w && idx_w == `TCC_IDX_PWR && hi_lane_w &&
                   wdat_w[`TCC_SWRST_BIT];
  wire restart_w = wr_w && idx_w == `TCC_IDX_CTRL_A && hi_lane_w &&
                   wdat_w[`TCC_RESTART_BIT];

  // ----------------------------------------------------------------
  // bus handshake: one wait cycle, then answer
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end else begin
      // drop for one cycle per request, then stall again
      avs_waitrequest_o <= ~(req_w & avs_waitrequest_o);
      if (avs_read_i && avs_waitrequest_o) begin
        if (idx_w == `TCC_IDX_PWR) begin
          // self-clearing reset bit reads as zero
          avs_readdata_o <= {16'h0000,
                             pwr_q & ~(16'h0001 << `TCC_SWRST_BIT)};
        end else if (idx_w == `TCC_IDX_CAL_EN) begin
          avs_readdata_o <= {16'h0000, cal_en_q};
        end else if (idx_w == `TCC_IDX_CTRL_A) begin
          // restart bit never holds a one
          avs_readdata_o <= {16'h0000, ctrl_a_q};
        end else if (idx_w == `TCC_IDX_CTRL_B) begin
          avs_readdata_o <= {16'h0000, ctrl_b_q};
        end else begin
          avs_readdata_o <= 32'h0000_0000;    // unmapped reads zero
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwr_q    <= `TCC_RST_PWR;
      cal_en_q <= `TCC_RST_CAL_EN;
      ctrl_a_q <= `TCC_RST_CTRL_A;
      ctrl_b_q <= `TCC_RST_CTRL_B;
      srst_q   <= 1'b0;
    end else begin
      srst_q <= swrst_w;
      if (swrst_w) begin
        // whole bank back to defaults, this register too
        pwr_q    <= `TCC_RST_PWR;
        cal_en_q <= `TCC_RST_CAL_EN;
        ctrl_a_q <= `TCC_RST_CTRL_A;
        ctrl_b_q <= `TCC_RST_CTRL_B;
      end else if (wr_w) begin
        if (idx_w == `TCC_IDX_PWR) begin
          pwr_q <= merge(pwr_q, wdat_w, avs_byteenable_i[1:0]);
        end else if (idx_w == `TCC_IDX_CAL_EN) begin
          cal_en_q <= merge(cal_en_q, wdat_w,
                            avs_byteenable_i[1:0]);
        end else if (idx_w == `TCC_IDX_CTRL_A) begin
          // restart is a strobe, so its bit is never stored
          ctrl_a_q <= merge(ctrl_a_q, wdat_w,
                            avs_byteenable_i[1:0]) &
                      ~(16'h0001 << `TCC_RESTART_BIT);
        end else if (idx_w == `TCC_IDX_CTRL_B) begin
          ctrl_b_q <= merge(ctrl_b_q, wdat_w, avs_byteenable_i[1:0]);
        end
        // unmapped writes are acknowledged and dropped
      end
    end
  end

  // ----------------------------------------------------------------
  // sequence scheduler
  // ----------------------------------------------------------------
  reg  [23:0] tick_cnt_q;                // cycles since last start
  wire [31:0] lp_per_w = LP_STEP_CYC * ({30'h0, lpdly_w} + 32'h1);
  wire [31:0] per_w    = full_w ? FP_PERIOD_CYC : lp_per_w;
  wire        per_hit_w = ({8'h00, tick_cnt_q} >= per_w - 32'h1);

  // shutdown parks the counter; no conversions at all
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_cnt_q    <= 24'h000000;
      conv_start_o  <= 1'b0;
      seq_restart_o <= 1'b0;
    end else begin
      conv_start_o  <= 1'b0;
      seq_restart_o <= restart_w;
      if (!run_w || srst_q || restart_w) begin
        tick_cnt_q <= 24'h000000;
      end else if (per_hit_w) begin
        tick_cnt_q   <= 24'h000000;
        conv_start_o <= 1'b1;
      end else begin
        tick_cnt_q <= tick_cnt_q + 24'h000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // sample averaging skip
  // ----------------------------------------------------------------
  reg  [4:0] smp_cnt_q;                  // samples skipped so far
  // full power: 3, 7, 15 or 31
  wire [4:0] fp_n_w = (5'h04 << fpskip_w) - 5'h01;
  wire [4:0] lp_n_w = {3'h0, lpskip_w};
  wire [4:0] skip_w = full_w ? fp_n_w : lp_n_w;

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      smp_cnt_q    <= 5'h00;
      sample_use_o <= 1'b0;
    end else begin
      sample_use_o <= 1'b0;
      if (srst_q || restart_w) begin
        smp_cnt_q <= 5'h00;
      end else if (sample_done_i && run_w) begin
        if (smp_cnt_q >= skip_w) begin
          smp_cnt_q    <= 5'h00;
          sample_use_o <= 1'b1;
        end else begin
          smp_cnt_q <= smp_cnt_q + 5'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // fast filter sequence skip
  // ----------------------------------------------------------------
  reg [3:0] ff_cnt_q;                    // sequences discarded

  // codes above the documented maximum are not guarded
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ff_cnt_q   <= 4'h0;
      ff_admit_o <= 1'b0;
    end else begin
      ff_admit_o <= 1'b0;
      if (srst_q || restart_w) begin
        ff_cnt_q <= 4'h0;
      end else if (seq_done_i && run_w) begin
        if (ff_cnt_q >= ffskip_w) begin
          ff_cnt_q   <= 4'h0;
          ff_admit_o <= 1'b1;
        end else begin
          ff_cnt_q <= ff_cnt_q + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // calibration hold and low power timeout
  // ----------------------------------------------------------------
  // hold periods counted in sequences
  // products formed at 32 bits, then cut to the 9-bit period on purpose
  wire [31:0] fp_prod_w = {28'h0000000, fphold_w} * `TCC_FP_HOLD_MUL;
  wire [31:0] lp_prod_w = {28'h0000000, lphold_w} * `TCC_LP_HOLD_MUL;
  wire [8:0] fp_hold_w = fp_prod_w[8:0];
  wire [8:0] lp_hold_w = lp_prod_w[8:0];
  wire [8:0] hold_w    = full_w ? fp_hold_w : lp_hold_w;
  // 1.25..2.00 times the full power hold: count * 4 * (5 + code)
  wire [8:0] tmo_val_w = {5'h00, fphold_w} *
                         ({7'h00, tmo_w} + 9'h005) * 9'h004;
  // a near object retriggers the hold each sequence, and the timeout in full power
  wire       prox_seq_w = proximity_i & seq_done_i & run_w;
  wire       hold_busy_w;
  wire       tmo_done_w;

  tcc_hold_timer #(.W(9)) u_hold (
    .ref_clk_i  (ref_clk_i),
    .arst_n_i   (arst_n_i),
    .clr_i      (srst_q),
    .load_i     (prox_seq_w),
    .load_val_i (hold_w),
    .tick_i     (seq_done_i & run_w),
    .busy_o     (hold_busy_w),
    .done_o     ()
  );

  // timeout only runs in full power
  tcc_hold_timer #(.W(9)) u_tmo (
    .ref_clk_i  (ref_clk_i),
    .arst_n_i   (arst_n_i),
    .clr_i      (srst_q | ~full_w),
    .load_i     (prox_seq_w),
    .load_val_i (tmo_val_w),
    .tick_i     (seq_done_i),
    .busy_o     (),
    .done_o     (tmo_done_w)
  );

  // ----------------------------------------------------------------
  // baseline update and status outputs
  // ----------------------------------------------------------------
  wire hold_now_w = proximity_i | hold_busy_w;
  wire [11:0] en_w = cal_en_q[`TCC_STAGES-1:0];

  // disabled stages still convert; their update is gated except under forced calibration
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      baseline_update_o <= 12'h000;
      cal_hold_o        <= 1'b0;
      lp_entry_o        <= 1'b0;
      stage_cal_enable_o <= 12'h000;
      forced_cal_o      <= 1'b0;
      power_mode_o      <= 2'h0;
    end else begin
      cal_hold_o     <= hold_now_w;
      lp_entry_o     <= tmo_done_w;
      stage_cal_enable_o <= en_w;
      forced_cal_o   <= ctrl_a_q[`TCC_FORCE_BIT];
      power_mode_o   <= mode_w;
      if (!(seq_done_i && run_w)) begin
        baseline_update_o <= 12'h000;
      end else if (ctrl_a_q[`TCC_FORCE_BIT]) begin
        baseline_update_o <= 12'hFFF;
      end else if (hold_now_w) begin
        baseline_update_o <= 12'h000;
      end else begin
        baseline_update_o <= en_w;
      end
    end
  end

endmodule

// ==== testbench/tcc_regs_assertions.sv ====
// tcc_regs_assertions.sv: bus and strobe checks for the register bank.
// assumes it is bound into tcc_regs and sees only its ports.
`timescale 1ns/1ps
module tcc_regs_chk (
  input wire        ref_clk_i,          // system clock
  input wire        arst_n_i,           // async reset, low
  input wire [7:0]  avs_address_i,      // byte address
  input wire        avs_read_i,         // read request
  input wire        avs_write_i,        // write request
  input wire [31:0] avs_writedata_i,    // write data
  input wire [3:0]  avs_byteenable_i,   // byte lanes
  input wire [31:0] avs_readdata_o,     // read data
  input wire        avs_waitrequest_o,  // stall
  input wire        sample_done_i,      // sample strobe
  input wire        seq_done_i,         // sequence strobe
  input wire        proximity_i,        // object near
  input wire        seq_restart_o,      // restart pulse
  input wire [1:0]  power_mode_o,       // mode copy
  input wire        forced_cal_o,       // forced copy
  input wire [11:0] baseline_update_o,  // baseline pulses
  input wire        sample_use_o,       // sample admitted
  input wire        ff_admit_o,         // fifo admit
  input wire        cal_hold_o,         // hold level
  input wire        lp_entry_o          // timeout pulse
);
  // ---------------------------------------------------------------
  // one clock domain, so one clocking and one disable
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // mode and forced copies lag one cycle, so the next cycle shows the
  // register values that the strobe edge itself used
  chk_wait_one: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("access not answered after one wait cycle");
  chk_wait_short: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  chk_wait_idle: assert property (!(avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest dropped without a request");
  chk_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o &&
    avs_address_i[7:2] > 6'h03 |-> avs_readdata_o == 32'h00000000)
    else $error("unmapped read not zero");
  chk_restart_reads: assert property (avs_read_i && !avs_waitrequest_o &&
    avs_address_i[7:2] == 6'h02 |-> !avs_readdata_o[15])
    else $error("restart bit reads back one");
  chk_restart_pulse: assert property (avs_write_i && !avs_waitrequest_o &&
    avs_address_i[7:2] == 6'h02 && avs_byteenable_i[1] &&
    avs_writedata_i[15] |=> seq_restart_o ##1 !seq_restart_o)
    else $error("restart pulse missing or long");
  chk_forced_all: assert property (seq_done_i |=> !forced_cal_o ||
    power_mode_o[0] || baseline_update_o == 12'hFFF)
    else $error("forced calibration did not update all stages");
  chk_shutdown_quiet: assert property ((seq_done_i || sample_done_i) |=>
    !power_mode_o[0] || (baseline_update_o == 12'h000 &&
    !sample_use_o && !ff_admit_o))
    else $error("activity in shutdown");
  chk_baseline_cause: assert property (baseline_update_o != 12'h000 |->
    $past(seq_done_i))
    else $error("baseline update without a sequence");
  chk_hold_prox: assert property (proximity_i |=> cal_hold_o)
    else $error("proximity did not hold calibration");
  // main scenarios reached
  cover property (seq_restart_o);
  cover property (baseline_update_o == 12'hFFF);
  cover property (lp_entry_o);
  cover property (ff_admit_o);
endmodule
bind tcc_regs tcc_regs_chk tcc_regs_chk_inst (.ref_clk_i(ref_clk_i),
  .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .sample_done_i(sample_done_i), .seq_done_i(seq_done_i),
  .proximity_i(proximity_i), .seq_restart_o(seq_restart_o),
  .power_mode_o(power_mode_o), .forced_cal_o(forced_cal_o),
  .baseline_update_o(baseline_update_o), .sample_use_o(sample_use_o),
  .ff_admit_o(ff_admit_o), .cal_hold_o(cal_hold_o),
  .lp_entry_o(lp_entry_o));

// ==== testbench/tcc_regs_tb.sv ====
// tcc_regs_tb.sv: self-checking bench for the calibration register bank.
// assumes tcc_regs with short scheduler periods and a 20 MHz clock.
`timescale 1ns/1ps
`define CHK(a,b) begin total_checks++; if ((a) !== (b)) begin \
  mismatches++; $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module tcc_regs_tb;
  logic        clk = 1'b0;     // system clock
  logic        rst_n = 1'b0;   // async reset, low
  logic [7:0]  addr = 8'h00;   // byte address
  logic        rd = 1'b0;      // read strobe
  logic        wr = 1'b0;      // write strobe
  logic [31:0] wdat = 32'h0;   // write data
  logic [3:0]  be = 4'hF;      // lanes
  logic        sd = 1'b0;      // sample strobe
  logic        qd = 1'b0;      // sequence strobe
  logic        px = 1'b0;      // proximity level
  wire  [31:0] rdat;           // read data
  wire         wreq;           // waitrequest
  wire         cs, rs, fc, su, ff, ch, lp; // single-bit outputs
  wire  [1:0]  pm;             // mode copy
  wire  [11:0] en, bl;         // enables, baseline pulses
  int          mismatches = 0;
  int          total_checks = 0;
  int          n_use, n_ff, n_bl, n_cs, n_rs, n_lp; // pulse counts
  logic [11:0] last_bl;        // last baseline pulse pattern
  int          fps[4] = '{3, 7, 15, 31};
  int          c, b;
  // short periods keep each scheduler mode check within 400 cycles
  tcc_regs #(.FP_PERIOD_CYC(40), .LP_STEP_CYC(20)) tcc_regs_inst (
    .ref_clk_i(clk), .arst_n_i(rst_n), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .sample_done_i(sd), .seq_done_i(qd),
    .proximity_i(px), .conv_start_o(cs), .seq_restart_o(rs),
    .power_mode_o(pm), .stage_cal_enable_o(en), .forced_cal_o(fc),
    .baseline_update_o(bl), .sample_use_o(su), .ff_admit_o(ff),
    .cal_hold_o(ch), .lp_entry_o(lp));
  // ---------------------------------------------------------------
  // clock and output pulse counters
  // ---------------------------------------------------------------
  always #25 clk = ~clk;
  always @(posedge clk) begin
    n_use += su; n_ff += ff; n_cs += cs; n_rs += rs; n_lp += lp;
    if (bl !== 12'h000) begin
      n_bl++;
      last_bl = bl;
    end
  end
  // ---------------------------------------------------------------
  // bus tasks: hold the request until waitrequest is sampled low
  // ---------------------------------------------------------------
  task automatic bus(input logic w, input [5:0] i, input [15:0] d,
                     input [3:0] l);
    int k;
    @(posedge clk);
    addr <= {i, 2'b00}; wdat <= {16'h0000, d}; be <= l;
    rd <= !w; wr <= w;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (wreq === 1'b0) break;
    end
    rd <= 1'b0; wr <= 1'b0;
    if (k == 20) begin mismatches++; stop_test(); end
  endtask
  task automatic wrr(input [5:0] i, input [15:0] d);
    bus(1'b1, i, d, 4'hF);
  endtask
  task automatic rdc(input [5:0] i, input [15:0] e);
    bus(1'b0, i, 16'h0000, 4'hF);
    `CHK(rdat, {16'h0000, e})
  endtask
  // back-to-back strobes, one per cycle, then a few settle cycles
  task automatic seq(input int n);
    repeat (n) @(posedge clk) qd <= 1'b1;
    @(posedge clk) qd <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic samp(input int n);
    repeat (n) @(posedge clk) sd <= 1'b1;
    @(posedge clk) sd <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // proximity on one sequence, then count the hold down to its end
  task automatic hold(input [15:0] w2, input int n, input bit tmo);
    wrr(2, w2); n_lp = 0;
    @(posedge clk) px <= 1'b1;
    seq(1);
    @(posedge clk) px <= 1'b0;
    b = n_bl;
    seq(n - 1);
    `CHK(ch, 1'b1)
    `CHK(n_bl, b)
    seq(1);
    `CHK(ch, 1'b0)
    if (tmo) begin
      seq(31 - n);
      `CHK(n_lp, 0)
      seq(1);
      `CHK(n_lp, 1)
    end
  endtask
  task automatic stop_test();
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rdc(0, 16'h0000);
    rdc(1, 16'h0000);
    rdc(2, 16'h0FF0);
    rdc(3, 16'h0164);
    rdc(6'h3F, 16'h0000);
    wrr(3, 16'hABCD); rdc(3, 16'hABCD);
    bus(1'b1, 1, 16'hFFFF, 4'h1); rdc(1, 16'h00FF);
    wrr(1, 16'h0FFF); rdc(1, 16'h0FFF);
    `CHK(en, 12'hFFF)
    seq(1); `CHK(last_bl, 12'hFFF)
    wrr(1, 16'h0005); seq(1); `CHK(last_bl, 12'h005)
    wrr(2, 16'h4FF0); seq(1); `CHK(last_bl, 12'hFFF)
    `CHK(fc, 1'b1)
    wrr(2, 16'h0FF0); seq(1); `CHK(last_bl, 12'h005)
    n_rs = 0; wrr(2, 16'h8FF0); rdc(2, 16'h0FF0);
    `CHK(n_rs, 1)
    for (c = 0; c < 4; c++) begin
      wrr(1, {2'b00, c[1:0], 12'h005}); wrr(2, 16'h8FF0); n_use = 0;
      samp(2 * (fps[c] + 1)); `CHK(n_use, 2)
    end
    wrr(0, 16'h0002);
    for (c = 0; c < 4; c++) begin
      wrr(1, {c[1:0], 14'h0005}); wrr(2, 16'h8FF0); n_use = 0;
      samp(2 * (c + 1)); `CHK(n_use, 2)
    end
    wrr(0, 16'h0000);
    foreach (fps[c]) begin
      b = (c == 3) ? 11 : c;
      wrr(2, 16'h8FF0 | b[15:0]); n_ff = 0;
      seq(2 * (b + 1)); `CHK(n_ff, 2)
    end
    // full, low power, then both shutdown codes
    for (c = 0; c < 4; c++) begin
      b = (c == 1) ? 2 : (c == 2) ? 1 : (c == 3) ? 3 : 0;
      wrr(0, b[15:0]);
      n_cs = 0; repeat (400) @(posedge clk);
      `CHK(pm, b[1:0])
      if (c >= 2) `CHK(n_cs, 0)
      else `CHK(n_cs >= 9 * (c + 1) && n_cs <= 11 * (c + 1), 1'b1)
    end
    n_bl = 0; n_use = 0; n_ff = 0; seq(3); samp(3);
    `CHK(n_bl + n_use + n_ff, 0)
    wrr(0, 16'h0000); hold(16'h3010, 16, 1'b1);
    wrr(0, 16'h0002); hold(16'h0100, 4, 1'b0);
    wrr(1, 16'h1234); wrr(0, 16'h0400);
    rdc(1, 16'h0000); rdc(2, 16'h0FF0); rdc(0, 16'h0000);
    rdc(3, 16'h0164);
    stop_test();
  end
endmodule
